// ==== design/scf_channel.sv ====
/*
 * Serial channel data path: line coding, echo and loopback, 4-byte transmit
 * FIFO, 8-byte receive FIFO, feature register and register port.
 * Assumes the far station is bit-aligned to the local bit-rate divider.
 */
`timescale 1ns/10ps
module scf_channel (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic rxd,
   input wire logic cts_n,
   input wire logic dcd_n,
   output logic txd,
   output logic tx_buf_irq_req,
   output logic rx_avail_irq_req,
   output logic tx_dma_req,
   output logic rx_dma_req,
   output logic dtr_req
);
   // ==========================================================
   // Pin synchronisers
   logic [2:0] pin_s1_r;   // First stage, read only by second stage
   logic [2:0] pin_s2_r;   // {dcd_n, cts_n, rxd}
   logic rxd_s;
   logic cts_on;
   logic dcd_on;

   // Idle line levels are high, so preset both stages high
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pin_s1_r <= 3'h7;
         pin_s2_r <= 3'h7;
      end else begin
         pin_s1_r <= {dcd_n, cts_n, rxd};
         pin_s2_r <= pin_s1_r;
      end
   end
   assign rxd_s = pin_s2_r[0];
   assign cts_on = ~pin_s2_r[1];
   assign dcd_on = ~pin_s2_r[2];

   // ==========================================================
   // Helper functions
   // One encoder step: at cell start or at mid-cell
   function automatic logic enc_step(input logic [1:0] enc, input logic lvl,
                                     input logic b, input logic mid);
      logic r;
      r = lvl;
      unique case (scf_pkg::scf_enc_e'(enc))
         scf_pkg::ENC_NRZ: r = mid ? lvl : b;
         scf_pkg::ENC_NRZI: r = (mid || b) ? lvl : ~lvl;
         scf_pkg::ENC_FM1: r = mid ? (lvl ^ b) : ~lvl;
         scf_pkg::ENC_FM0: r = mid ? (lvl ^ ~b) : ~lvl;
      endcase
      return r;
   endfunction : enc_step

   // CCITT CRC, one bit
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      logic fb;
      fb = c[15] ^ b;
      return {c[14:0], 1'b0} ^ (fb ? scf_pkg::CRC_POLY : scf_pkg::CRC_ZERO);
   endfunction : crc_step

   // ==========================================================
   // Configuration registers
   scf_pkg::scf_cfg_s cfg_r, cfg_nxt;
   logic [1:0] enc;        // Selected encoding
   logic chan_rst;         // Hardware or channel reset
   logic wr_data;
   logic rd_data;
   assign chan_rst = rst | (reg_wr && reg_addr == scf_pkg::IDX_CMD
                            && reg_wdata[scf_pkg::CMD_CHAN_RST]);
   assign enc = cfg_r.line[scf_pkg::LC_ENC_LO +: 2];
   assign wr_data = reg_wr && reg_addr == scf_pkg::IDX_DATA;
   assign rd_data = reg_rd && reg_addr == scf_pkg::IDX_DATA;

   // Register writes; index 7 steers by the select bit
   always_comb begin
      cfg_nxt = cfg_r;
      if (reg_wr) begin
         case (reg_addr)
            scf_pkg::IDX_WR3: cfg_nxt.wr3 = reg_wdata;
            scf_pkg::IDX_WR4: cfg_nxt.wr4 = reg_wdata;
            scf_pkg::IDX_WR5: cfg_nxt.wr5 = reg_wdata;
            scf_pkg::IDX_LINE: cfg_nxt.line = reg_wdata;
            scf_pkg::IDX_MISC: cfg_nxt.misc = reg_wdata;
            scf_pkg::IDX_EXT: cfg_nxt.ext = reg_wdata;
            scf_pkg::IDX_SYNC: begin
               if (cfg_r.ext[scf_pkg::EXT_FEAT_SEL]) begin
                  cfg_nxt.feat = reg_wdata & scf_pkg::FEAT_WMASK;
               end else begin
                  cfg_nxt.sync = reg_wdata;
               end
            end
            default: ;   // Other indices hold nothing here
         endcase
      end
   end

   // Feature register keeps its value until reset or rewrite
   always_ff @(posedge core_clk) begin
      if (chan_rst) begin
         cfg_r <= '{feat: scf_pkg::FEAT_RST, default: scf_pkg::REG_RST};
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // ==========================================================
   // Bit-rate divider, free running so coding never stops
   logic [7:0] qtr_cnt_r, qtr_cnt_nxt;
   logic [1:0] phase_r, phase_nxt;
   logic tick;
   logic cell_start;
   logic cell_mid;
   logic samp1;
   logic samp3;
   assign tick = qtr_cnt_r == scf_pkg::QTR_CYC - 8'h01;
   assign cell_start = tick && phase_r == 2'h3;
   assign cell_mid = tick && phase_r == 2'h1;
   assign samp1 = tick && phase_r == 2'h0;
   assign samp3 = tick && phase_r == 2'h2;

   // Quarter-cell counter and phase
   always_comb begin
      qtr_cnt_nxt = tick ? 8'h00 : qtr_cnt_r + 8'h01;
      phase_nxt = tick ? phase_r + 2'h1 : phase_r;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         qtr_cnt_r <= 8'h00;
         phase_r <= 2'h0;
      end else begin
         qtr_cnt_r <= qtr_cnt_nxt;
         phase_r <= phase_nxt;
      end
   end

   // ==========================================================
   // Transmit FIFO, four bytes, always enabled
   logic [7:0] txf_mem [0:3];
   logic [1:0] txf_wp_r, txf_wp_nxt;
   logic [1:0] txf_rp_r, txf_rp_nxt;
   logic [2:0] txf_cnt_r, txf_cnt_nxt;
   logic txf_push;
   logic tx_pop;                          // From the transmitter
   assign txf_push = wr_data && txf_cnt_r != scf_pkg::TXF_DEPTH;

   // Pointers and count; a write to a full FIFO is dropped
   always_comb begin
      txf_wp_nxt = txf_push ? txf_wp_r + 2'h1 : txf_wp_r;
      txf_rp_nxt = tx_pop ? txf_rp_r + 2'h1 : txf_rp_r;
      txf_cnt_nxt = txf_cnt_r + {2'h0, txf_push} - {2'h0, tx_pop};
   end

   always_ff @(posedge core_clk) begin
      if (chan_rst) begin
         txf_wp_r <= 2'h0;
         txf_rp_r <= 2'h0;
         txf_cnt_r <= 3'h0;
      end else begin
         txf_wp_r <= txf_wp_nxt;
         txf_rp_r <= txf_rp_nxt;
         txf_cnt_r <= txf_cnt_nxt;
      end
      if (txf_push) begin
         txf_mem[txf_wp_r] <= reg_wdata;
      end
   end

   // ==========================================================
   // Transmitter and line encoder
   scf_pkg::scf_tx_e tx_st_r, tx_st_nxt;
   logic [7:0] tx_sh_r, tx_sh_nxt;
   logic [2:0] tx_bc_r, tx_bc_nxt;
   logic tx_bit_r, tx_bit_nxt;            // Bit in the current cell
   logic line_r, line_nxt;                // Encoded transmit level
   logic eom_r, eom_nxt;                  // Underrun / end-of-message latch
   logic [15:0] crc_r, crc_nxt;
   logic tx_ok;
   logic [15:0] crc_preset;
   logic load;
   logic eom_clr_cmd;
   // Echo and loopback ignore the clear-to-send enable
   assign tx_ok = cfg_r.misc[scf_pkg::MC_TX_EN] && (cts_on
                  || cfg_r.misc[scf_pkg::MC_ECHO] || cfg_r.misc[scf_pkg::MC_LOOP]);
   assign crc_preset = cfg_r.line[scf_pkg::LC_CRC_ONES] ? scf_pkg::CRC_ONES : scf_pkg::CRC_ZERO;
   assign eom_clr_cmd = reg_wr && reg_addr == scf_pkg::IDX_CMD
                        && reg_wdata[scf_pkg::CMD_EOM_CLR];

   // Bit sequencing at cell start, encoding at start and mid-cell
   always_comb begin
      tx_st_nxt = tx_st_r;
      tx_sh_nxt = tx_sh_r;
      tx_bc_nxt = tx_bc_r;
      tx_bit_nxt = tx_bit_r;
      line_nxt = line_r;
      eom_nxt = eom_r;
      crc_nxt = crc_r;
      tx_pop = 1'b0;
      load = 1'b0;
      if (eom_clr_cmd) begin
         eom_nxt = 1'b0;
         crc_nxt = crc_preset;
      end
      if (cell_start) begin
         if (tx_st_r == scf_pkg::TX_IDLE || tx_bc_r == 3'h7) begin
            if (txf_cnt_r != 3'h0 && tx_ok) begin
               load = 1'b1;
               if (tx_st_r == scf_pkg::TX_IDLE && cfg_r.feat[scf_pkg::FT_AUTO_FLAG]) begin
                  tx_st_nxt = scf_pkg::TX_FLAG;
                  tx_sh_nxt = scf_pkg::FLAG_BYTE;
               end else begin
                  tx_st_nxt = scf_pkg::TX_DATA;
                  tx_sh_nxt = txf_mem[txf_rp_r];
                  tx_pop = 1'b1;
                  if (cfg_r.feat[scf_pkg::FT_AUTO_EOM] && eom_r) begin
                     eom_nxt = 1'b0;
                     crc_nxt = crc_preset;
                  end
               end
               tx_bc_nxt = 3'h0;
            end else begin
               // Nothing to send: idle marks, flag a data underrun
               if (tx_st_r == scf_pkg::TX_DATA) begin
                  eom_nxt = 1'b1;
               end
               tx_st_nxt = scf_pkg::TX_IDLE;
            end
         end else begin
            tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
            tx_bc_nxt = tx_bc_r + 3'h1;
         end
         tx_bit_nxt = (tx_st_nxt == scf_pkg::TX_IDLE) ? 1'b1 : tx_sh_nxt[0];
         if (tx_st_nxt == scf_pkg::TX_DATA) begin
            crc_nxt = crc_step(crc_nxt, tx_bit_nxt);
         end
         line_nxt = enc_step(enc, line_r, tx_bit_nxt, 1'b0);
      end else if (cell_mid) begin
         line_nxt = enc_step(enc, line_r, tx_bit_r, 1'b1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (chan_rst) begin
         tx_st_r <= scf_pkg::TX_IDLE;
         tx_sh_r <= 8'h00;
         tx_bc_r <= 3'h0;
         tx_bit_r <= 1'b1;
         line_r <= 1'b1;
         eom_r <= 1'b0;
         crc_r <= scf_pkg::CRC_ZERO;
      end else begin
         tx_st_r <= tx_st_nxt;
         tx_sh_r <= tx_sh_nxt;
         tx_bc_r <= tx_bc_nxt;
         tx_bit_r <= tx_bit_nxt;
         line_r <= line_nxt;
         eom_r <= eom_nxt;
         crc_r <= crc_nxt;
      end
   end

   // Echo bypasses the transmitter; echoed data keeps its coding
   assign txd = cfg_r.misc[scf_pkg::MC_ECHO] ? rxd_s : line_r;

   // ==========================================================
   // Receiver and decoder
   logic rx_in;
   logic rx_ok;
   logic h1_r, h1_nxt;                   // First-half sample
   logic prev_r, prev_nxt;               // Previous cell's first half
   logic [7:0] rx_sh_r, rx_sh_nxt;
   logic [2:0] rx_bc_r, rx_bc_nxt;
   logic rx_bit;
   logic rx_push;
   logic [7:0] rx_byte;
   // Loopback takes the encoded line and ignores the pin and DCD
   assign rx_in = cfg_r.misc[scf_pkg::MC_LOOP] ? line_r : rxd_s;
   assign rx_ok = cfg_r.misc[scf_pkg::MC_RX_EN] && (dcd_on || cfg_r.misc[scf_pkg::MC_LOOP]);

   // Decode one cell from the quarter-one and quarter-three samples
   always_comb begin
      unique case (scf_pkg::scf_enc_e'(enc))
         scf_pkg::ENC_NRZ: rx_bit = cfg_r.misc[scf_pkg::MC_BIPHASE_RX] ? h1_r : rx_in;
         scf_pkg::ENC_NRZI: rx_bit = h1_r == prev_r;
         scf_pkg::ENC_FM1: rx_bit = h1_r != rx_in;
         scf_pkg::ENC_FM0: rx_bit = h1_r == rx_in;
      endcase
      h1_nxt = samp1 ? rx_in : h1_r;
      prev_nxt = samp3 ? h1_r : prev_r;
      rx_sh_nxt = rx_sh_r;
      rx_bc_nxt = rx_bc_r;
      rx_push = 1'b0;
      rx_byte = {rx_bit, rx_sh_r[7:1]};
      if (samp3 && rx_ok) begin
         rx_sh_nxt = rx_byte;
         rx_bc_nxt = rx_bc_r + 3'h1;
         rx_push = rx_bc_r == 3'h7;
      end
   end

   always_ff @(posedge core_clk) begin
      if (chan_rst) begin
         h1_r <= 1'b1;
         prev_r <= 1'b1;
         rx_sh_r <= 8'h00;
         rx_bc_r <= 3'h0;
      end else begin
         h1_r <= h1_nxt;
         prev_r <= prev_nxt;
         rx_sh_r <= rx_sh_nxt;
         rx_bc_r <= rx_bc_nxt;
      end
   end

   // ==========================================================
   // Receive FIFO, eight bytes, always enabled
   logic [7:0] rxf_mem [0:7];
   logic [2:0] rxf_wp_r, rxf_wp_nxt;
   logic [2:0] rxf_rp_r, rxf_rp_nxt;
   logic [3:0] rxf_cnt_r, rxf_cnt_nxt;
   logic ovr_r, ovr_nxt;
   logic rxf_wr;
   logic rxf_rd;
   logic blk_r, blk_nxt;                 // Request held off after a burst
   assign rxf_wr = rx_push && rxf_cnt_r != scf_pkg::RXF_DEPTH;
   assign rxf_rd = rd_data && rxf_cnt_r != 4'h0;

   // Overrun set wins over its clear command
   always_comb begin
      rxf_wp_nxt = rxf_wr ? rxf_wp_r + 3'h1 : rxf_wp_r;
      rxf_rp_nxt = rxf_rd ? rxf_rp_r + 3'h1 : rxf_rp_r;
      rxf_cnt_nxt = rxf_cnt_r + {3'h0, rxf_wr} - {3'h0, rxf_rd};
      ovr_nxt = ovr_r;
      if (reg_wr && reg_addr == scf_pkg::IDX_CMD && reg_wdata[scf_pkg::CMD_OVR_CLR]) begin
         ovr_nxt = 1'b0;
      end
      if (rx_push && !rxf_wr) begin
         ovr_nxt = 1'b1;
      end
      blk_nxt = blk_r;
      if (rxf_cnt_r > 4'h1) begin
         blk_nxt = 1'b1;
      end else if (rxf_cnt_r == 4'h0) begin
         blk_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (chan_rst) begin
         rxf_wp_r <= 3'h0;
         rxf_rp_r <= 3'h0;
         rxf_cnt_r <= 4'h0;
         ovr_r <= 1'b0;
         blk_r <= 1'b0;
      end else begin
         rxf_wp_r <= rxf_wp_nxt;
         rxf_rp_r <= rxf_rp_nxt;
         rxf_cnt_r <= rxf_cnt_nxt;
         ovr_r <= ovr_nxt;
         blk_r <= blk_nxt;
      end
      if (rxf_wr) begin
         rxf_mem[rxf_wp_r] <= rx_byte;
      end
   end

   // ==========================================================
   // Requests; software masks interrupts, these are levels
   logic tx_top_free;
   logic tx_req_lvl;
   logic [2:0] dtr_hold_r, dtr_hold_nxt;
   assign tx_top_free = txf_cnt_r != scf_pkg::TXF_DEPTH;
   assign tx_req_lvl = cfg_r.feat[scf_pkg::FT_TX_LEVEL] ? txf_cnt_r == 3'h0 : tx_top_free;
   assign tx_buf_irq_req = tx_req_lvl;
   assign tx_dma_req = cfg_r.misc[scf_pkg::MC_DMA_TX_EN] && tx_req_lvl;
   assign rx_avail_irq_req = cfg_r.feat[scf_pkg::FT_RX_LEVEL] ? rxf_cnt_r >= scf_pkg::RX_HALF
                             : rxf_cnt_r != 4'h0;
   assign rx_dma_req = cfg_r.misc[scf_pkg::MC_DMA_RX_EN] && rxf_cnt_r == 4'h1 && !blk_r;
   // Terminal-ready request lingers four clocks unless timing bit set
   assign dtr_req = tx_dma_req || (!cfg_r.feat[scf_pkg::FT_REQ_TIMING]
                    && dtr_hold_r != 3'h0);

   // Release counter reloads while the request stands
   always_comb begin
      if (tx_dma_req) begin
         dtr_hold_nxt = scf_pkg::REQ_RELEASE_CLK;
      end else if (dtr_hold_r != 3'h0) begin
         dtr_hold_nxt = dtr_hold_r - 3'h1;
      end else begin
         dtr_hold_nxt = 3'h0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (chan_rst) begin
         dtr_hold_r <= 3'h0;
      end else begin
         dtr_hold_r <= dtr_hold_nxt;
      end
   end

   // ==========================================================
   // Read port: data in the cycle after the strobe
   logic [7:0] rdata_r, rdata_nxt;
   logic [7:0] status;
   logic ext_rd;
   assign ext_rd = cfg_r.feat[scf_pkg::FT_EXT_READ];
   always_comb begin
      status = 8'h00;
      status[scf_pkg::ST_RX_AVAIL] = rxf_cnt_r != 4'h0;
      status[scf_pkg::ST_TX_EMPTY] = tx_top_free;
      status[scf_pkg::ST_DCD] = dcd_on;
      status[scf_pkg::ST_CTS] = cts_on;
      status[scf_pkg::ST_EOM] = eom_r;
      status[scf_pkg::ST_RX_OVR] = ovr_r;
   end

   // Extended read indices return write-side registers
   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            scf_pkg::IDX_STATUS: rdata_nxt = status;
            scf_pkg::IDX_DATA: rdata_nxt = rxf_cnt_r != 4'h0 ? rxf_mem[rxf_rp_r] : 8'h00;
            scf_pkg::IDX_EXT: rdata_nxt = cfg_r.ext;
            scf_pkg::IDX_RD_WR3: rdata_nxt = ext_rd ? cfg_r.wr3 : 8'h00;
            scf_pkg::IDX_WR4: rdata_nxt = ext_rd ? cfg_r.wr4 : 8'h00;
            scf_pkg::IDX_WR5: rdata_nxt = ext_rd ? cfg_r.wr5 : 8'h00;
            scf_pkg::IDX_RD_FEAT: rdata_nxt = ext_rd ? cfg_r.feat : 8'h00;
            scf_pkg::IDX_RD_LINE: rdata_nxt = ext_rd ? cfg_r.line : 8'h00;
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end
   assign reg_rdata = rdata_r;
endmodule : scf_channel

// ==== design/scf_pkg.sv ====
/*
 * Shared constants and types for the serial channel data path: register
 * indices, field positions, reset values, timing counts and carrier structs.
 * Assumes one 10 MHz system clock and an 8-bit register port indexed 0..15.
 */
package scf_pkg;
   // ==========================================================
   // Register indices
   localparam logic [3:0] IDX_STATUS = 4'h0;   // Main status (read)
   localparam logic [3:0] IDX_WR3 = 4'h3;      // Receive parameters (write)
   localparam logic [3:0] IDX_WR4 = 4'h4;      // Mode parameters (write, ext read)
   localparam logic [3:0] IDX_WR5 = 4'h5;      // Transmit parameters (write, ext read)
   localparam logic [3:0] IDX_SYNC = 4'h7;     // Sync character or feature register
   localparam logic [3:0] IDX_DATA = 4'h8;     // Transmit push / receive pop
   localparam logic [3:0] IDX_CMD = 4'h9;      // Command strobes (write)
   localparam logic [3:0] IDX_RD_WR3 = 4'h9;   // Receive parameter readback
   localparam logic [3:0] IDX_LINE = 4'ha;     // Line control (write)
   localparam logic [3:0] IDX_RD_LINE = 4'hb;  // Line control readback
   localparam logic [3:0] IDX_MISC = 4'he;     // Channel mode control (write)
   localparam logic [3:0] IDX_RD_FEAT = 4'he;  // Feature readback
   localparam logic [3:0] IDX_EXT = 4'hf;      // External interrupt control
   // ==========================================================
   // Field positions
   localparam int LC_ENC_LO = 5;        // Encoding field is bits 6:5
   localparam int LC_CRC_ONES = 7;      // CRC preset to all ones
   localparam int FT_AUTO_FLAG = 0;
   localparam int FT_AUTO_EOM = 1;
   localparam int FT_AUTO_RTS = 2;
   localparam int FT_RX_LEVEL = 3;
   localparam int FT_REQ_TIMING = 4;
   localparam int FT_TX_LEVEL = 5;
   localparam int FT_EXT_READ = 6;
   localparam int EXT_FEAT_SEL = 0;
   localparam int MC_ECHO = 0;
   localparam int MC_LOOP = 1;
   localparam int MC_BIPHASE_RX = 2;
   localparam int MC_TX_EN = 3;
   localparam int MC_RX_EN = 4;
   localparam int MC_DMA_TX_EN = 5;
   localparam int MC_DMA_RX_EN = 6;
   localparam int CMD_CHAN_RST = 0;
   localparam int CMD_EOM_CLR = 1;
   localparam int CMD_OVR_CLR = 2;
   localparam int ST_RX_AVAIL = 0;
   localparam int ST_TX_EMPTY = 2;
   localparam int ST_DCD = 3;
   localparam int ST_CTS = 5;
   localparam int ST_EOM = 6;
   localparam int ST_RX_OVR = 7;
   // ==========================================================
   // Reset values and fixed patterns
   localparam logic [7:0] FEAT_RST = 8'h20;
   localparam logic [7:0] FEAT_WMASK = 8'h7f;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [7:0] FLAG_BYTE = 8'h7e;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_ONES = 16'hffff;
   localparam logic [15:0] CRC_ZERO = 16'h0000;
   localparam logic [2:0] TXF_DEPTH = 3'h4;
   localparam logic [3:0] RXF_DEPTH = 4'h8;
   localparam logic [3:0] RX_HALF = 4'h4;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int BIT_TIME_NS = 1600;
   localparam logic [7:0] QTR_CYC = 8'(BIT_TIME_NS / (4 * CLK_PERIOD_NS));
   localparam logic [2:0] REQ_RELEASE_CLK = 3'h4;   // In system clock periods
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      ENC_NRZ = 2'b00,
      ENC_NRZI = 2'b01,
      ENC_FM1 = 2'b10,
      ENC_FM0 = 2'b11
   } scf_enc_e;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_FLAG = 2'b01,
      TX_DATA = 2'b10
   } scf_tx_e;
   typedef struct packed {
      logic [7:0] feat;    // fifo_feature_control
      logic [7:0] line;    // line_control_reg
      logic [7:0] ext;     // ext_interrupt_control_reg
      logic [7:0] sync;    // sync_character_reg
      logic [7:0] wr3;
      logic [7:0] wr4;
      logic [7:0] wr5;
      logic [7:0] misc;
   } scf_cfg_s;
endpackage : scf_pkg

// ==== testbench/scf_channel_sva.sv ====
/* Port checker for scf_channel.
   Bound onto the top module; one clock, synchronous reset. */
`timescale 1ns/10ps
module scf_channel_sva (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic tx_buf_irq_req,
   input wire logic rx_avail_irq_req,
   input wire logic tx_dma_req,
   input wire logic rx_dma_req,
   input wire logic dtr_req
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // ==========
   // Status read strobe
   logic st_rd;
   assign st_rd = reg_rd && reg_addr == 4'h0;
   property p_rst; $fell(rst) |-> tx_buf_irq_req && !rx_avail_irq_req; endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_txq; tx_dma_req |-> tx_buf_irq_req; endproperty
   a_txq: assert property (p_txq) else $error("tx request");
   property p_tbe; st_rd && tx_buf_irq_req |=> reg_rdata[2]; endproperty
   a_tbe: assert property (p_tbe) else $error("tx status");
   property p_rxa; st_rd && (rx_avail_irq_req || rx_dma_req) |=> reg_rdata[0]; endproperty
   a_rxa: assert property (p_rxa) else $error("rx status");
   property p_id; reg_wr && reg_addr == 4'hf ##2 reg_rd && reg_addr == 4'hf
      |=> reg_rdata[0] == $past(reg_wdata[0], 3); endproperty
   a_id: assert property (p_id) else $error("ident");
   property p_f7; reg_rd && reg_addr == 4'he |=> !reg_rdata[7]; endproperty
   a_f7: assert property (p_f7) else $error("feature bit 7");
   property p_crst; reg_wr && reg_addr == 4'h9 && reg_wdata[0]
      |=> tx_buf_irq_req && !rx_avail_irq_req && !rx_dma_req; endproperty
   a_crst: assert property (p_crst) else $error("channel reset");
   // Release hold of the terminal-ready request after a transmit request drops
   property p_dtr; $fell(tx_dma_req) && dtr_req |-> dtr_req [*3] ##[1:3] !dtr_req; endproperty
   a_dtr: assert property (p_dtr) else $error("dtr release");
   c_dtr: cover property (dtr_req && !tx_dma_req);
   c_rxq: cover property (rx_dma_req);
   c_rxa: cover property (st_rd && rx_avail_irq_req);
endmodule : scf_channel_sva
bind scf_channel scf_channel_sva u_sva (.*);

// ==== testbench/scf_remote.sv ====
/* Remote station on the serial line.
   The bench picks its behaviour through md. */
`timescale 1ns/10ps
module scf_remote (
   input wire logic core_clk,
   input wire logic [1:0] md,
   input wire logic txd,
   output logic rxd,
   output logic cts_n,
   output logic dcd_n
);
   // ==========
   // 1 loops the line back and raises controls; 0 marks idle; 2 holds space
   always_ff @(posedge core_clk) begin
      rxd <= (md == 2'h1) ? txd : (md == 2'h0);
      cts_n <= md != 2'h1;
      dcd_n <= md != 2'h1;
   end
endmodule : scf_remote

// ==== testbench/scf_channel_tb.sv ====
/* Bench for scf_channel with remote station and port checker.
   Register calls leave one idle cycle between strobes. */
`timescale 1ns/10ps
module scf_channel_tb;
   logic core_clk, rst, reg_wr, reg_rd, txd, rxd, cts_n, dcd_n, dtr_req;
   logic tx_buf_irq_req, rx_avail_irq_req, tx_dma_req, rx_dma_req;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, v;
   logic [1:0] md;
   int err_total, comparisons, cyc, n;
   // Toggles per four cells: idle ones, then 0x55, one byte per encoding
   localparam logic [31:0] IDL = 32'h04080000;
   localparam logic [31:0] DAT = 32'h06060204;
   scf_channel DUT (.*);
   scf_remote u_rem (.*);
   initial begin
      core_clk = 0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_total++;
         summarize();
      end
   end
   task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s exp %h seen %h", s, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge core_clk);
   endtask : rd
   // Counts line changes over four cells, sampled mid-cycle
   task automatic tog(output int c);
      logic q;
      c = 0;
      @(negedge core_clk) q = txd;
      repeat (64) @(negedge core_clk) begin
         c += int'(txd !== q);
         q = txd;
      end
      @(posedge core_clk);
   endtask : tog
   task automatic summarize();
      if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   initial begin
      {rst, reg_wr, reg_rd, reg_addr, reg_wdata, md} = 17'h10000;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      chk("tbe_rst", tx_buf_irq_req, 1);
      wr(4'h8, 8'ha5);
      chk("tbe_one", tx_buf_irq_req, 0);
      rd(4'h0, v);
      chk("st_top", v[2], 1);
      wr(4'hf, 8'h01);
      rd(4'hf, v);
      chk("ident", v, 8'h01);
      wr(4'h7, 8'hc8);
      rd(4'he, v);
      chk("feat", v, 8'h48);
      chk("tbe_top", tx_buf_irq_req, 1);
      repeat (4) wr(4'h8, 8'h55);
      rd(4'h0, v);
      chk("st_full", v[2], 0);
      wr(4'ha, 8'h20);
      rd(4'hb, v);
      chk("line", v, 8'h20);
      wr(4'hf, 8'h00);
      wr(4'h7, 8'h11);
      rd(4'he, v);
      chk("sync", v, 8'h48);
      wr(4'h9, 8'h01);
      chk("tbe_crst", tx_buf_irq_req, 1);
      md <= 2'h1;
      for (int e = 0; e < 4; e++) begin
         wr(4'ha, 8'(e << 5));
         wr(4'he, 8'h20);
         chk("tx_dma", {tx_dma_req, dtr_req}, 8'h03);
         tog(n);
         chk("idle", n[7:0], IDL[e*8 +: 8]);
         repeat (4) wr(4'h8, 8'h55);
         wr(4'he, 8'h28);
         chk("dtr_off", dtr_req, 0);
         repeat (80) @(posedge core_clk);
         tog(n);
         chk("data", n[7:0], DAT[e*8 +: 8]);
         repeat (700) @(posedge core_clk);
      end
      wr(4'he, 8'h01);
      md <= 2'h2;
      repeat (8) @(posedge core_clk);
      chk("echo0", txd, 0);
      md <= 2'h0;
      repeat (8) @(posedge core_clk);
      chk("echo1", txd, 1);
      wr(4'h9, 8'h01);
      md <= 2'h2;
      wr(4'he, 8'h52);
      for (n = 0; n < 700 && !rx_avail_irq_req; n++) @(negedge core_clk);
      @(posedge core_clk);
      rd(4'h0, v);
      chk("rx_st", v[0], 1);
      chk("rx_req", rx_dma_req, 1);
      repeat (130) @(posedge core_clk);
      chk("rx_req2", rx_dma_req, 0);
      wr(4'hf, 8'h01);
      wr(4'h7, 8'h28);
      chk("rx_lvl", rx_avail_irq_req, 0);
      for (n = 0; n < 700 && !rx_avail_irq_req; n++) @(negedge core_clk);
      @(posedge core_clk);
      chk("rx_half", rx_avail_irq_req, 1);
      rd(4'h8, v);
      chk("rx_byte", v, 8'hff);
      wr(4'h9, 8'h01);
      chk("rx_flush", rx_avail_irq_req, 0);
      summarize();
   end
endmodule : scf_channel_tb
